// File: src/bus_frame_host_relay.sv
// Relays received bus frames to the host byte stream with checks, CRC and end marking.
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ps
module bus_frame_host_relay #(
	parameter int GAP_CYCLES = int'(relay_pkg::GAP_CYCLES_DFLT)
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic in_valid,
	input wire logic [1:0] in_kind,
	input wire logic [7:0] in_data,
	output logic in_ready,
	output logic host_valid,
	output logic [7:0] host_data,
	input wire logic host_ready,
	output logic poll_strobe,
	output logic [3:0] poll_slot_out,
	output logic [7:0] poll_state_out,
	output logic bus_tx_valid,
	output logic [7:0] bus_tx_data,
	input wire logic bus_tx_ready
);
	import relay_pkg::*;

	typedef struct packed {
		seq_type state;
		logic host_valid;
		logic [7:0] host_data;
		logic in_ready;
		logic dup;
		logic [15:0] crc;
		logic [7:0] xsum;
		logic [8:0] cnt;
		logic [8:0] len;
		logic ext;
		logic poll;
		logic [7:0] fstate;
		logic [2:0] feat;
		logic [1:0] mode;
		logic [3:0] poll_slot;
		logic [7:0] poll_pstate;
		logic [15:0] poll_addr;
		logic poll_armed;
		logic [15:0] rx_paddr;
		logic poll_strobe;
		logic btx_valid;
		logic [7:0] btx_data;
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
		logic [GAP_W-1:0] gap;
	} relay_type;

	relay_type r_reg;
	relay_type r_next;

	// Byte-wise CRC step, no reflection and no final xor.
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] v;
		v = c ^ {b, 8'h00};
		for (int i = 0; i < 8; i++) begin
			v = v[15] ? ((v << 1) ^ CRC_POLY) : (v << 1);
		end
		return v;
	endfunction

	// Next state after the frame body, chosen from mode and features.
	function automatic seq_type after_body(input logic [2:0] f, input logic [1:0] m);
		if (f[FEAT_MARKER]) begin
			return f[FEAT_CRC] ? S_CRCH : S_MARK;
		end else if (m != MODE_UART9) begin
			return S_STATE;
		end
		return f[FEAT_CRC] ? S_CRCH : S_GAP;
	endfunction

	logic emit;
	logic [7:0] ob;
	logic [15:0] cbase;
	logic free;
	logic [8:0] expect_len;
	logic ce;

	// Sequencer, bus slave and poll handling all compute one next copy of the state.
	always_comb begin
		r_next = r_reg;
		emit = 1'b0;
		ob = 8'h00;
		cbase = r_reg.crc;
		expect_len = r_reg.len + (r_reg.ext ? LEN_EXTRA_EXT : LEN_EXTRA_STD);
		ce = 1'b0;
		r_next.pready = 1'b0;
		r_next.pslverr = 1'b0;
		r_next.poll_strobe = 1'b0;
		if (r_reg.host_valid && host_ready) begin
			r_next.host_valid = 1'b0;
		end
		if (r_reg.btx_valid && bus_tx_ready) begin
			r_next.btx_valid = 1'b0;
		end
		free = !r_reg.host_valid || host_ready;
		case (r_reg.state)
			S_IDLE, S_FRAME, S_SKIP: begin
				if (free && r_reg.dup) begin
					emit = 1'b1;
					ob = FRAME_END_CODE;
					r_next.dup = 1'b0;
				end else if (free && in_valid && r_reg.in_ready) begin
					case (in_kind)
						KIND_CTRL: begin
							if (r_reg.state == S_IDLE) begin
								cbase = CRC_INIT;
								r_next.xsum = in_data;
								r_next.cnt = 9'h001;
								r_next.len = 9'h000;
								r_next.ext = (in_data & CTRL_MASK) == CTRL_EXT;
								r_next.poll = in_data == CTRL_POLL;
								if (((in_data & CTRL_MASK) == CTRL_STD) ||
									((in_data & CTRL_MASK) == CTRL_EXT) ||
									(in_data == CTRL_POLL)) begin
									emit = 1'b1;
									ob = in_data;
									r_next.state = S_FRAME;
								end else begin
									r_next.state = S_SKIP;
								end
							end
						end
						KIND_DATA: begin
							if (r_reg.state == S_FRAME) begin
								emit = 1'b1;
								ob = in_data;
								r_next.dup = r_reg.feat[FEAT_MARKER] &&
									(in_data == FRAME_END_CODE);
								r_next.xsum = r_reg.xsum ^ in_data;
								r_next.cnt = r_reg.cnt + 9'h001;
								if (!r_reg.poll && !r_reg.ext && r_reg.cnt == IDX_LEN_STD) begin
									r_next.len = {5'h00, in_data[3:0]};
								end
								if (!r_reg.poll && r_reg.ext && r_reg.cnt == IDX_LEN_EXT) begin
									r_next.len = {1'b0, in_data};
								end
								if (r_reg.poll && r_reg.cnt == IDX_PADDR_HI) begin
									r_next.rx_paddr[15:8] = in_data;
								end
								if (r_reg.poll && r_reg.cnt == IDX_PADDR_LO) begin
									r_next.rx_paddr[7:0] = in_data;
								end
								if (r_reg.poll && r_reg.cnt == IDX_SLOTS && r_reg.poll_armed &&
									r_reg.rx_paddr == r_reg.poll_addr &&
									in_data[3:0] > r_reg.poll_slot) begin
									r_next.poll_strobe = 1'b1;
									r_next.poll_armed = r_reg.feat[FEAT_AUTOPOLL];
								end
							end
						end
						KIND_END: begin
							if (r_reg.state == S_FRAME) begin
								ce = !r_reg.poll &&
									((r_reg.xsum != CSUM_OK) || (r_reg.cnt != expect_len));
								r_next.fstate = FSTATE_CODE;
								r_next.fstate[FS_RX_ERR] = in_data[END_RX_ERR];
								r_next.fstate[FS_CSUM_ERR] = ce;
								r_next.fstate[FS_TIMING_ERR] = in_data[END_TIMING_ERR];
								r_next.state = after_body(r_reg.feat, r_reg.mode);
								r_next.gap = '0;
							end else if (r_reg.state == S_SKIP) begin
								r_next.state = S_IDLE;
							end
						end
						default: begin
							if (r_reg.state == S_IDLE) begin
								emit = 1'b1;
								ob = in_data;
								r_next.dup = r_reg.feat[FEAT_MARKER] &&
									(in_data == FRAME_END_CODE);
							end
						end
					endcase
				end
			end
			S_STATE: begin
				if (free) begin
					emit = 1'b1;
					ob = r_reg.fstate;
					r_next.state = r_reg.feat[FEAT_CRC] ? S_CRCH : S_GAP;
				end
			end
			S_CRCH: begin
				if (free) begin
					emit = 1'b1;
					ob = r_reg.crc[15:8];
					r_next.state = S_CRCL;
				end
			end
			S_CRCL: begin
				if (free) begin
					emit = 1'b1;
					ob = r_reg.crc[7:0];
					r_next.state = r_reg.feat[FEAT_MARKER] ? S_MARK : S_GAP;
				end
			end
			S_MARK: begin
				if (free) begin
					emit = 1'b1;
					ob = FRAME_END_CODE;
					r_next.state = S_MSTATE;
				end
			end
			S_MSTATE: begin
				if (free) begin
					emit = 1'b1;
					ob = r_reg.fstate;
					r_next.state = S_IDLE;
				end
			end
			S_GAP: begin
				if (!r_reg.host_valid) begin
					if (r_reg.gap == GAP_W'(GAP_CYCLES - 1)) begin
						r_next.state = S_IDLE;
					end else begin
						r_next.gap = r_reg.gap + 1'b1;
					end
				end
			end
			default: begin
				r_next.state = S_IDLE;
			end
		endcase
		// CRC bytes themselves are not folded into the running value.
		if (emit) begin
			r_next.host_valid = 1'b1;
			r_next.host_data = ob;
			if (r_reg.state != S_CRCH && r_reg.state != S_CRCL) begin
				r_next.crc = crc_step(cbase, ob);
			end
		end
		// APB slave answers one cycle into the access phase.
		if (psel && penable && !r_reg.pready) begin
			r_next.pready = 1'b1;
			r_next.prdata = 32'h0000_0000;
			case (paddr)
				CONFIG_OFS: begin
					if (pwrite) begin
						r_next.feat = r_reg.feat | pwdata[2:0];
						r_next.mode = pwdata[MODE_LSB+1:MODE_LSB];
					end
					r_next.prdata = {26'h0, r_reg.mode, 1'b0, r_reg.feat};
				end
				STATUS_OFS: begin
					r_next.prdata = {23'h0, r_reg.poll_armed, r_reg.fstate};
				end
				POLL_SLOT_OFS: begin
					if (pwrite) begin
						r_next.poll_slot = pwdata[3:0];
						r_next.poll_pstate = pwdata[15:8];
						r_next.poll_armed = 1'b1;
					end
					r_next.prdata = {16'h0, r_reg.poll_pstate, 4'h0, r_reg.poll_slot};
				end
				POLL_ADDR_OFS: begin
					if (pwrite) begin
						r_next.poll_addr = pwdata[15:0];
					end
					r_next.prdata = {16'h0, r_reg.poll_addr};
				end
				MPOLL_OFS: begin
					if (pwrite && !r_reg.btx_valid) begin
						r_next.btx_valid = 1'b1;
						r_next.btx_data = pwdata[7:0];
					end else if (pwrite) begin
						r_next.pslverr = 1'b1;
					end
					r_next.prdata = {31'h0, r_reg.btx_valid};
				end
				default: begin
					r_next.pslverr = 1'b1;
				end
			endcase
		end
		r_next.in_ready = ((r_next.state == S_IDLE) || (r_next.state == S_FRAME) ||
			(r_next.state == S_SKIP)) && !r_next.dup && !r_next.host_valid;
	end

	// State register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_reg <= '0;
			r_reg.state <= S_IDLE;
			r_reg.crc <= CRC_INIT;
		end else begin
			r_reg <= r_next;
		end
	end

	// Outputs straight from the state register.
	assign prdata = r_reg.prdata;
	assign pready = r_reg.pready;
	assign pslverr = r_reg.pslverr;
	assign in_ready = r_reg.in_ready;
	assign host_valid = r_reg.host_valid;
	assign host_data = r_reg.host_data;
	assign poll_strobe = r_reg.poll_strobe;
	assign poll_slot_out = r_reg.poll_slot;
	assign poll_state_out = r_reg.poll_pstate;
	assign bus_tx_valid = r_reg.btx_valid;
	assign bus_tx_data = r_reg.btx_data;
endmodule

// File: src/relay_pkg.sv
// Shared constants and types for the bus frame to host relay.
package relay_pkg;
	// Register byte offsets on the APB bus.
	localparam logic [7:0] CONFIG_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] POLL_SLOT_OFS = 8'h08;
	localparam logic [7:0] POLL_ADDR_OFS = 8'h0C;
	localparam logic [7:0] MPOLL_OFS = 8'h10;
	// Feature bits in the configuration register.
	localparam int FEAT_MARKER = 0;
	localparam int FEAT_CRC = 1;
	localparam int FEAT_AUTOPOLL = 2;
	localparam int MODE_LSB = 4;
	// Host link modes.
	localparam logic [1:0] MODE_SPI = 2'h0;
	localparam logic [1:0] MODE_UART8 = 2'h1;
	localparam logic [1:0] MODE_UART9 = 2'h2;
	// Kinds of byte arriving from the bus side.
	localparam logic [1:0] KIND_CTRL = 2'h0;
	localparam logic [1:0] KIND_DATA = 2'h1;
	localparam logic [1:0] KIND_END = 2'h2;
	localparam logic [1:0] KIND_ECHO = 2'h3;
	// Error flag positions in the end byte from the bus receiver.
	localparam int END_RX_ERR = 0;
	localparam int END_TIMING_ERR = 1;
	// Frame state byte layout; bit 4 is reserved and reads zero.
	localparam logic [7:0] FSTATE_CODE = 8'h03;
	localparam int FS_RX_ERR = 7;
	localparam int FS_CSUM_ERR = 6;
	localparam int FS_TIMING_ERR = 5;
	// Control byte classification.
	localparam logic [7:0] CTRL_MASK = 8'hD3;
	localparam logic [7:0] CTRL_STD = 8'h90;
	localparam logic [7:0] CTRL_EXT = 8'h10;
	localparam logic [7:0] CTRL_POLL = 8'hF0;
	// Frame end marker code and checksum target.
	localparam logic [7:0] FRAME_END_CODE = 8'hCB;
	localparam logic [7:0] CSUM_OK = 8'hFF;
	// Byte positions inside a frame, control byte at index 0.
	localparam logic [8:0] IDX_LEN_STD = 9'h005;
	localparam logic [8:0] IDX_LEN_EXT = 9'h006;
	localparam logic [8:0] IDX_PADDR_HI = 9'h003;
	localparam logic [8:0] IDX_PADDR_LO = 9'h004;
	localparam logic [8:0] IDX_SLOTS = 9'h005;
	localparam logic [8:0] LEN_EXTRA_STD = 9'h008;
	localparam logic [8:0] LEN_EXTRA_EXT = 9'h009;
	// Frame check generator.
	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	localparam logic [15:0] CRC_POLY = 16'h1021;
	// Silence that ends a frame without marker.
	localparam longint GAP_TIME_NS = 2600000;
	localparam longint CLK_MHZ = 50;
	localparam longint GAP_CYCLES_DFLT = (GAP_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int GAP_W = 18;
	typedef enum logic [8:0] {
		S_IDLE = 9'h001,
		S_FRAME = 9'h002,
		S_SKIP = 9'h004,
		S_STATE = 9'h008,
		S_CRCH = 9'h010,
		S_CRCL = 9'h020,
		S_MARK = 9'h040,
		S_MSTATE = 9'h080,
		S_GAP = 9'h100
	} seq_type;
endpackage

// File: verification/bus_frame_host_relay_assertions.sv
// Concurrent checks on the relay's register, stream and poll ports.
`timescale 1ns/1ps
module relay_checker
	import relay_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic in_valid,
	input wire logic in_ready,
	input wire logic host_valid,
	input wire logic [7:0] host_data,
	input wire logic host_ready,
	input wire logic poll_strobe,
	input wire logic bus_tx_valid,
	input wire logic [7:0] bus_tx_data,
	input wire logic bus_tx_ready
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [2:0] feat_reg;
	// Features written so far; writing zero never clears one.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			feat_reg <= 3'h0;
		end else if (psel && penable && pready && pwrite && paddr == CONFIG_OFS) begin
			feat_reg <= feat_reg | pwdata[2:0];
		end
	end
	// An access that completes in this cycle.
	sequence s_done;
		psel && penable && pready;
	endsequence
	// A master poll byte accepted by the register bus.
	sequence s_mpoll;
		s_done ##0 (pwrite && paddr == MPOLL_OFS && !pslverr);
	endsequence
	property p_one_wait;
		psel && penable && !pready |=> pready;
	endproperty
	property p_unmapped;
		s_done ##0 (paddr > MPOLL_OFS) |-> pslverr;
	endproperty
	property p_err_with_ready;
		pslverr |-> pready;
	endproperty
	property p_sticky;
		s_done ##0 (!pwrite && paddr == CONFIG_OFS) |-> prdata[2:0] == feat_reg;
	endproperty
	property p_host_hold;
		host_valid && !host_ready |=> host_valid && $stable(host_data);
	endproperty
	property p_take_drop;
		in_valid && in_ready ##1 host_valid |-> !in_ready;
	endproperty
	property p_poll_pulse;
		poll_strobe |=> !poll_strobe;
	endproperty
	property p_mpoll_out;
		s_mpoll |-> bus_tx_valid && bus_tx_data == pwdata[7:0];
	endproperty
	property p_tx_hold;
		bus_tx_valid && !bus_tx_ready |=> bus_tx_valid && $stable(bus_tx_data);
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("pready late");
	a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
	a_err_with_ready: assert property (p_err_with_ready) else $error("stray pslverr");
	a_sticky: assert property (p_sticky) else $error("feature bits lost");
	a_host_hold: assert property (p_host_hold) else $error("host byte changed");
	a_take_drop: assert property (p_take_drop) else $error("in_ready held");
	a_poll_pulse: assert property (p_poll_pulse) else $error("poll strobe long");
	a_mpoll_out: assert property (p_mpoll_out) else $error("poll byte not sent");
	a_tx_hold: assert property (p_tx_hold) else $error("bus byte changed");
endmodule
bind bus_frame_host_relay relay_checker chk (
	.pclk(pclk),
	.presetn(presetn),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.pwdata(pwdata),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr),
	.in_valid(in_valid),
	.in_ready(in_ready),
	.host_valid(host_valid),
	.host_data(host_data),
	.host_ready(host_ready),
	.poll_strobe(poll_strobe),
	.bus_tx_valid(bus_tx_valid),
	.bus_tx_data(bus_tx_data),
	.bus_tx_ready(bus_tx_ready)
);

// File: verification/host_link_model.sv
// Host side model that takes relayed bytes, promptly or with stalls.
`timescale 1ns/1ps
module host_link_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic host_valid,
	input wire logic [7:0] host_data,
	input wire logic stall,
	output logic host_ready
);
	logic [7:0] got[$];
	// Record each byte taken; when stalling, accept only every other cycle.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			host_ready <= 1'b0;
		end else begin
			host_ready <= !stall || !host_ready;
			if (host_valid && host_ready) got.push_back(host_data);
		end
	end
endmodule

// File: verification/bus_frame_host_relay_tb.sv
// Directed bench for the bus frame to host relay.
`timescale 1ns/1ps
module bus_frame_host_relay_tb;
	import relay_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
	logic [7:0] paddr = 0, in_data = 0, host_data, bus_tx_data, poll_state_out, pstate;
	logic [31:0] pwdata = 0, prdata, rd;
	logic in_valid = 0, in_ready, host_valid, host_ready, stall = 0, pready, pslverr;
	logic poll_strobe, bus_tx_valid, bus_tx_ready = 0;
	logic [1:0] in_kind = 0;
	logic [3:0] poll_slot_out, pslot;
	logic [15:0] c;
	logic [7:0] exp[$];
	int mismatches = 0, check_count = 0, strobes = 0, gap_n = 0;
	localparam int GAP_SIM = 20;
	bus_frame_host_relay #(.GAP_CYCLES(GAP_SIM)) uut (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.in_valid(in_valid),
		.in_kind(in_kind),
		.in_data(in_data),
		.in_ready(in_ready),
		.host_valid(host_valid),
		.host_data(host_data),
		.host_ready(host_ready),
		.poll_strobe(poll_strobe),
		.poll_slot_out(poll_slot_out),
		.poll_state_out(poll_state_out),
		.bus_tx_valid(bus_tx_valid),
		.bus_tx_data(bus_tx_data),
		.bus_tx_ready(bus_tx_ready)
	);
	host_link_model host (
		.pclk(pclk),
		.presetn(presetn),
		.host_valid(host_valid),
		.host_data(host_data),
		.stall(stall),
		.host_ready(host_ready)
	);
	initial forever #10 pclk = ~pclk;
	// Note each poll slot pulse with the slot and state it carries.
	always @(posedge pclk) begin
		if (poll_strobe === 1'b1) begin
			strobes++;
			pslot = poll_slot_out;
			pstate = poll_state_out;
		end
	end
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	// Bitwise frame check, MSB first, no reflection, no final inversion.
	function automatic logic [15:0] crc(input logic [7:0] q[$]);
		logic [15:0] r;
		r = 16'hFFFF;
		foreach (q[i]) for (int j = 7; j >= 0; j--) r = {r[14:0], 1'b0} ^ ((r[15] ^ q[i][j]) ? 16'h1021 : 16'h0);
		return r;
	endfunction
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		n = 0;
		do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
		if (n >= 50) mismatches++;
	endtask
	task put(input logic [1:0] k, input logic [7:0] d);
		int n;
		in_valid <= 1;
		in_kind <= k;
		in_data <= d;
		n = 0;
		do @(posedge pclk); while (in_ready !== 1'b1 && ++n < 200);
		if (n >= 200) mismatches++;
	endtask
	// Adds frame check, marker and state byte to the expected stream.
	task tail(input logic [7:0] st);
		c = crc(exp);
		exp.push_back(c[15:8]);
		exp.push_back(c[7:0]);
		exp.push_back(8'hCB);
		exp.push_back(st);
	endtask
	// Lets the tail drain, then holds the host stream against the expected bytes.
	task drain;
		repeat (150) @(posedge pclk);
		chk("host count", exp.size(), host.got.size());
		foreach (exp[i]) chk("host byte", exp[i], host.got[i]);
		host.got.delete();
		exp.delete();
	endtask
	// Sends one frame and counts the edges until the relay takes bytes again.
	task frame(input logic [7:0] b[$], input logic [7:0] endf);
		put(KIND_CTRL, b[0]);
		for (int i = 1; i < b.size(); i++) put(KIND_DATA, b[i]);
		put(KIND_END, endf);
		in_valid <= 0;
		gap_n = 0;
		do begin
			@(posedge pclk);
			gap_n++;
		end while (in_ready !== 1'b1 && gap_n < 200);
		drain;
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		#200000;
		mismatches++;
		test_done;
	end
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		chk("crc vector", 16'h29B1, crc('{8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h37, 8'h38, 8'h39}));
		apb(0, CONFIG_OFS, 32'h0);
		chk("config reset", 32'h0, rd);
		apb(0, 8'h14, 32'h0);
		chk("unmapped err", 1, er);
		// Short frame, bad length, no features, host stalling.
		stall <= 1;
		exp = '{8'hBC, 8'h11, 8'hCB, 8'h43};
		frame('{8'hBC, 8'h11, 8'hCB}, 8'h00);
		apb(0, STATUS_OFS, 32'h0);
		chk("status", 8'h43, rd[7:0]);
		frame('{8'h00, 8'h11}, 8'h00);
		// Extended frame in 9-bit UART mode: no state byte, silence ends the frame.
		apb(1, CONFIG_OFS, 32'h20);
		exp = '{8'h10, 8'h11, 8'h22, 8'h33, 8'h44, 8'h00, 8'h01, 8'h00, 8'h80, 8'h2A};
		frame('{8'h10, 8'h11, 8'h22, 8'h33, 8'h44, 8'h00, 8'h01, 8'h00, 8'h80, 8'h2A}, 8'h00);
		chk("gap cycles", GAP_SIM + 1, gap_n);
		apb(0, STATUS_OFS, 32'h0);
		chk("status ext", 8'h03, rd[7:0]);
		apb(1, CONFIG_OFS, 32'h3);
		apb(1, CONFIG_OFS, 32'h0);
		apb(0, CONFIG_OFS, 32'h0);
		chk("features", 32'h3, rd);
		// Good frame with marker and frame check, both error flags set.
		exp = '{8'hBC, 8'hCB, 8'hCB, 8'h11, 8'h22, 8'h33, 8'hE0, 8'h44, 8'h2C};
		tail(8'hA3);
		frame('{8'hBC, 8'hCB, 8'h11, 8'h22, 8'h33, 8'hE0, 8'h44, 8'h2C}, 8'h03);
		// Slave poll: slot 2 armed, bus offers three slots.
		apb(1, POLL_ADDR_OFS, 32'h1234);
		apb(1, POLL_SLOT_OFS, 32'h5A02);
		exp = '{8'hF0, 8'h11, 8'h22, 8'h12, 8'h34, 8'h03, 8'h00};
		tail(8'h03);
		frame('{8'hF0, 8'h11, 8'h22, 8'h12, 8'h34, 8'h03, 8'h00}, 8'h00);
		chk("strobes", 1, strobes);
		chk("poll slot", 4'h2, pslot);
		chk("poll state", 8'h5A, pstate);
		// Master poll byte, second write refused while the bus stalls.
		stall <= 0;
		apb(1, MPOLL_OFS, 32'hA5);
		apb(1, MPOLL_OFS, 32'h5C);
		chk("busy err", 1, er);
		chk("tx data", 8'hA5, bus_tx_data);
		bus_tx_ready <= 1;
		repeat (3) @(posedge pclk);
		chk("tx idle", 0, bus_tx_valid);
		// Auto-poll keeps the slot armed; too few slots on the bus gives no pulse.
		apb(1, CONFIG_OFS, 32'h4);
		apb(1, POLL_SLOT_OFS, 32'h5A02);
		exp = '{8'hF0, 8'h11, 8'h22, 8'h12, 8'h34, 8'h03, 8'h00};
		tail(8'h03);
		frame('{8'hF0, 8'h11, 8'h22, 8'h12, 8'h34, 8'h03, 8'h00}, 8'h00);
		exp = '{8'hF0, 8'h11, 8'h22, 8'h12, 8'h34, 8'h02, 8'h00};
		tail(8'h03);
		frame('{8'hF0, 8'h11, 8'h22, 8'h12, 8'h34, 8'h02, 8'h00}, 8'h00);
		chk("strobes again", 2, strobes);
		apb(0, STATUS_OFS, 32'h0);
		chk("armed kept", 1, rd[8]);
		// A transmit echo of the end code reaches the host twice with the marker on.
		exp = '{8'hCB, 8'hCB};
		put(KIND_ECHO, 8'hCB);
		in_valid <= 0;
		drain;
		test_done;
	end
endmodule
